// ### src/spi_port_pkg.sv
// constants and types shared by the serial port block
package spi_port_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam int CNT_W = 5;
	localparam int DIV_W = 11;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h220;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h222;
	localparam logic [ADDR_W-1:0] OFS_BUFFER = 12'h224;
	localparam logic [ADDR_W-1:0] OFS_IRQ = 12'h226;

	// reset values
	localparam logic [DATA_W-1:0] RST_CONTROL = 16'h0000;
	localparam logic [DATA_W-1:0] RST_BUFFER = 16'h0000;

	// port_status fields
	localparam int ST_ENABLE_BIT = 15;
	localparam int ST_IDLE_STOP_BIT = 13;
	localparam int ST_OVF_BIT = 6;
	localparam int ST_TBF_BIT = 1;
	localparam int ST_RBF_BIT = 0;

	// port_control fields
	localparam int CT_FRAMED_BIT = 14;
	localparam int CT_FRAME_SYNC_PULSE_DIR_BIT = 13;
	localparam int CT_OUT_DIS_BIT = 11;
	localparam int CT_WIDE_BIT = 10;
	localparam int CT_PHASE_BIT = 9;
	localparam int CT_EDGE_BIT = 8;
	localparam int CT_SEL_EN_BIT = 7;
	localparam int CT_IDLE_POL_BIT = 6;
	localparam int CT_MASTER_BIT = 5;
	localparam int CT_SEC_HI = 4;
	localparam int CT_SEC_LO = 2;
	localparam int CT_PRI_HI = 1;
	localparam int CT_PRI_LO = 0;

	// interrupt register fields
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_EN_BIT = 1;

	// clock division
	localparam int BASE_DIV = 4;
	localparam int HALF_BASE = BASE_DIV / 2;
	localparam int PRI_DIV0 = 64;
	localparam int PRI_DIV1 = 16;
	localparam int PRI_DIV2 = 4;
	localparam int PRI_DIV3 = 1;
	localparam int SEC_TOP = 8;

	// word lengths
	localparam logic [CNT_W-1:0] NARROW_BITS = 5'h08;
	localparam logic [CNT_W-1:0] WIDE_BITS = 5'h10;

	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_SYNC, ST_SHIFT} fsm_t;
endpackage

// ### src/spi_port.sv
// serial port: register slave, prescaler, shifter and pin control
//
// Local design decision: strobed register access.
`timescale 1ns/100ps

// Function
// - each transfer shifts 8 or 16 bits out and in, one per clock
// - transfer end sets done flag; enable bit gates the interrupt request
// - completion with unread receive data sets overflow and drops the word
// - overflow freezes the port until software reads the buffer or clears the overflow bit
// - at word end, shifter goes to receive buffer, pending transmit word loads
// - buffer writes go to transmit side, reads return receive side
// - master drives prescaled clock and starts when buffer is written
// - master raises done at the middle of the last bit
// - slave shifts on external clock, done when last bit latched
// - clock is core over four, then primary and secondary prescale
// - polarity bit picks idle level, edge bit picks data change edge
// - word size bit 10 selects 16-bit when set, 8-bit when clear
// - port resets whenever word size bit changes
// - output from bit 7 or 15, input enters bit 0
// - output disable bit stops driving the data output
// - framed mode turns select pin into frame sync, master or slave
// - frame direction bit picks received or generated frame pulse
// - frame pulse high one serial clock, data starts next transmit edge
// - slave with select shifts and drives output only while select low
// - select rising resets counters so next word restarts at msb
// - sleep aborts transfer, register contents kept
// - idle halts port when stop-in-idle set, runs when clear
module spi_port
	import spi_port_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic sleep_mode,
	input wire logic idle_mode,
	input wire logic serial_data_in_pin,
	output logic serial_data_out_pin,
	output logic serial_data_out_pin_oe,
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe,
	input wire logic slave_select_pin_n_in,
	output logic slave_select_pin_n_out,
	output logic slave_select_pin_n_oe,
	output logic transfer_irq
);

	typedef struct packed {
		logic [DATA_W-1:0] ctl;
		logic port_enable;
		logic sidl;
		logic rov;
		logic tbf;
		logic rbf;
		logic [DATA_W-1:0] txbuf;
		logic [DATA_W-1:0] rxbuf;
		logic [DATA_W-1:0] sr;
		fsm_t state;
		logic [CNT_W-1:0] bitcnt;
		logic [CNT_W:0] halfcnt;
		logic [DIV_W-1:0] divcnt;
		logic sck_prev;
		logic ss_prev;
		logic pend;
		logic irq_flag;
		logic irq_en;
		logic irq;
		logic sck_out;
		logic sck_oe;
		logic sdo_out;
		logic sdo_oe;
		logic ss_out;
		logic ss_oe;
		logic [DATA_W-1:0] rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	function automatic logic [6:0] pri_div(input logic [1:0] sel);
		unique case (sel)
			2'h0: pri_div = 7'(PRI_DIV0);
			2'h1: pri_div = 7'(PRI_DIV1);
			2'h2: pri_div = 7'(PRI_DIV2);
			2'h3: pri_div = 7'(PRI_DIV3);
		endcase
	endfunction

	function automatic logic word_msb(input logic [DATA_W-1:0] w, input logic wide);
		word_msb = wide ? w[15] : w[7];
	endfunction

	logic wr_status, wr_control, wr_buffer, wr_irq, rd_buffer;
	logic master, framed, frame_out, sel_used, sel_high, wide, clock_idle_polarity, cke;
	logic wide_chg, port_on, running, port_rst, edge_ok;
	logic tick, sck_edge, lead, trail, sample_e, change_e, done_e;
	logic [CNT_W-1:0] nbits;
	logic [DIV_W-1:0] half_cnt;
	logic [DATA_W-1:0] shifted;
	logic [3:0] sec_div;

	assign wr_status = reg_wr && reg_addr == OFS_STATUS;
	assign wr_control = reg_wr && reg_addr == OFS_CONTROL;
	assign wr_buffer = reg_wr && reg_addr == OFS_BUFFER;
	assign wr_irq = reg_wr && reg_addr == OFS_IRQ;
	assign rd_buffer = reg_rd && reg_addr == OFS_BUFFER;

	assign master = st_r.ctl[CT_MASTER_BIT];
	assign framed = st_r.ctl[CT_FRAMED_BIT];
	assign frame_out = framed && !st_r.ctl[CT_FRAME_SYNC_PULSE_DIR_BIT];
	assign sel_used = !master && st_r.ctl[CT_SEL_EN_BIT] && !framed;
	assign sel_high = sel_used && slave_select_pin_n_in;
	assign wide = st_r.ctl[CT_WIDE_BIT];
	assign clock_idle_polarity = st_r.ctl[CT_IDLE_POL_BIT];
	assign cke = st_r.ctl[CT_EDGE_BIT];
	assign nbits = wide ? WIDE_BITS : NARROW_BITS;

	assign wide_chg = wr_control && reg_wdata[CT_WIDE_BIT] != wide;
	assign port_on = st_r.port_enable && !sleep_mode;
	assign running = port_on && !(idle_mode && st_r.sidl) && !st_r.rov;
	assign port_rst = !port_on || wide_chg;
	assign edge_ok = running && !sel_high;

	assign sec_div = 4'(SEC_TOP) - {1'b0, st_r.ctl[CT_SEC_HI:CT_SEC_LO]};
	assign half_cnt = DIV_W'(HALF_BASE * pri_div(st_r.ctl[CT_PRI_HI:CT_PRI_LO]) * sec_div);
	assign tick = master && running && st_r.state != ST_IDLE &&
		st_r.divcnt == half_cnt - 11'h001;

	// one unified edge pair for both roles
	assign sck_edge = master ? tick : shift_clock_pin_in != st_r.sck_prev;
	assign lead = edge_ok && sck_edge && (master ? st_r.sck_out : st_r.sck_prev) == clock_idle_polarity;
	assign trail = edge_ok && sck_edge && (master ? st_r.sck_out : st_r.sck_prev) != clock_idle_polarity;
	assign sample_e = cke ? lead : trail;
	assign change_e = cke ? trail : lead;
	assign done_e = st_r.state == ST_SHIFT && sample_e && st_r.bitcnt == nbits - 5'h01;
	assign shifted = {st_r.sr[14:0], serial_data_in_pin};

	always_comb begin
		st_nxt = st_r;
		st_nxt.sck_prev = shift_clock_pin_in;
		st_nxt.ss_prev = slave_select_pin_n_in;
		st_nxt.rdata = 16'h0000;

		// register side
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS: begin
					st_nxt.rdata[ST_ENABLE_BIT] = st_r.port_enable;
					st_nxt.rdata[ST_IDLE_STOP_BIT] = st_r.sidl;
					st_nxt.rdata[ST_OVF_BIT] = st_r.rov;
					st_nxt.rdata[ST_TBF_BIT] = st_r.tbf;
					st_nxt.rdata[ST_RBF_BIT] = st_r.rbf;
				end
				OFS_CONTROL: st_nxt.rdata = st_r.ctl;
				OFS_BUFFER: st_nxt.rdata = st_r.rxbuf;
				OFS_IRQ: begin
					st_nxt.rdata[IRQ_FLAG_BIT] = st_r.irq_flag;
					st_nxt.rdata[IRQ_EN_BIT] = st_r.irq_en;
				end
				default: st_nxt.rdata = 16'h0000;
			endcase
		end
		if (wr_control) begin
			st_nxt.ctl = reg_wdata;
		end
		if (wr_status) begin
			st_nxt.port_enable = reg_wdata[ST_ENABLE_BIT];
			st_nxt.sidl = reg_wdata[ST_IDLE_STOP_BIT];
			if (!reg_wdata[ST_OVF_BIT]) begin
				st_nxt.rov = 1'b0;
			end
		end
		if (wr_irq) begin
			st_nxt.irq_en = reg_wdata[IRQ_EN_BIT];
			if (!reg_wdata[IRQ_FLAG_BIT]) begin
				st_nxt.irq_flag = 1'b0;
			end
		end
		if (wr_buffer) begin
			st_nxt.txbuf = reg_wdata;
		end
		if (rd_buffer) begin
			st_nxt.rbf = 1'b0;
			st_nxt.rov = 1'b0;
		end

		// master clock divider
		if (tick || st_r.state == ST_IDLE) begin
			st_nxt.divcnt = 11'h000;
		end else if (running) begin
			st_nxt.divcnt = st_r.divcnt + 11'h001;
		end
		if (tick) begin
			st_nxt.sck_out = !st_r.sck_out;
		end
		if (lead || trail) begin
			st_nxt.halfcnt = st_r.halfcnt + 6'h01;
		end

		unique case (st_r.state)
			ST_IDLE: begin
				st_nxt.halfcnt = 6'h00;
				st_nxt.bitcnt = 5'h00;
				st_nxt.sck_out = clock_idle_polarity;
				if (running && (!master || st_r.tbf || st_r.pend)) begin
					if (st_r.tbf && !st_r.pend) begin
						st_nxt.sr = st_r.txbuf;
						st_nxt.tbf = 1'b0;
						st_nxt.sdo_out = word_msb(st_r.txbuf, wide);
					end
					st_nxt.pend = 1'b0;
					if (!framed) begin
						st_nxt.state = ST_SHIFT;
					end else if (frame_out) begin
						st_nxt.state = ST_FRAME;
						st_nxt.ss_out = 1'b1;
					end else begin
						st_nxt.state = ST_SYNC;
					end
				end
			end
			ST_FRAME: begin
				// pulse spans one lead and one trail edge
				if ((lead || trail) && st_r.halfcnt == 6'h01) begin
					st_nxt.ss_out = 1'b0;
					st_nxt.halfcnt = 6'h00;
					st_nxt.state = ST_SHIFT;
				end
			end
			ST_SYNC: begin
				st_nxt.halfcnt = 6'h00;
				if (lead && slave_select_pin_n_in) begin
					st_nxt.state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (change_e) begin
					st_nxt.sdo_out = word_msb(st_r.sr, wide);
				end
				if (sample_e) begin
					st_nxt.sr = shifted;
					st_nxt.bitcnt = st_r.bitcnt + 5'h01;
				end
				if (!master && st_r.bitcnt == 5'h00 && st_r.tbf && !sample_e && !change_e) begin
					st_nxt.sr = st_r.txbuf;
					st_nxt.tbf = 1'b0;
					st_nxt.sdo_out = word_msb(st_r.txbuf, wide);
				end
				if (done_e) begin
					st_nxt.bitcnt = 5'h00;
					if (!st_r.rbf) begin
						st_nxt.rxbuf = wide ? shifted : {8'h00, shifted[7:0]};
					end
					if (st_r.tbf) begin
						st_nxt.sr = st_r.txbuf;
						st_nxt.tbf = 1'b0;
						st_nxt.pend = master;
					end
					if (!master && framed) begin
						st_nxt.state = frame_out ? ST_FRAME : ST_SYNC;
						st_nxt.ss_out = frame_out;
						st_nxt.halfcnt = 6'h00;
					end
				end
				if (master && tick && st_r.halfcnt == {nbits, 1'b0} - 6'h01) begin
					st_nxt.state = ST_IDLE;
				end
			end
		endcase

		// select release restarts the word
		if (sel_used && slave_select_pin_n_in && !st_r.ss_prev) begin
			st_nxt.state = ST_IDLE;
			st_nxt.bitcnt = 5'h00;
			st_nxt.halfcnt = 6'h00;
		end

		if (port_rst) begin
			st_nxt.state = ST_IDLE;
			st_nxt.bitcnt = 5'h00;
			st_nxt.halfcnt = 6'h00;
			st_nxt.divcnt = 11'h000;
			st_nxt.sck_out = wr_control ? reg_wdata[CT_IDLE_POL_BIT] : clock_idle_polarity;
			st_nxt.ss_out = 1'b0;
			st_nxt.pend = 1'b0;
			if (wide_chg) begin
				st_nxt.tbf = 1'b0;
				st_nxt.rbf = 1'b0;
				st_nxt.rov = 1'b0;
			end
		end

		// hardware sets win over clears
		if (done_e) begin
			st_nxt.irq_flag = 1'b1;
			if (st_r.rbf) begin
				st_nxt.rov = 1'b1;
			end else begin
				st_nxt.rbf = 1'b1;
			end
		end
		if (wr_buffer) begin
			st_nxt.tbf = 1'b1;
		end

		st_nxt.irq = st_nxt.irq_flag && st_nxt.irq_en;
		st_nxt.sck_oe = st_nxt.port_enable && !sleep_mode && st_nxt.ctl[CT_MASTER_BIT];
		st_nxt.sdo_oe = port_on && !st_r.ctl[CT_OUT_DIS_BIT] && !sel_high;
		st_nxt.ss_oe = port_on && frame_out;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign serial_data_out_pin = st_r.sdo_out;
	assign serial_data_out_pin_oe = st_r.sdo_oe;
	assign shift_clock_pin_out = st_r.sck_out;
	assign shift_clock_pin_oe = st_r.sck_oe;
	assign slave_select_pin_n_out = st_r.ss_out;
	assign slave_select_pin_n_oe = st_r.ss_oe;
	assign transfer_irq = st_r.irq;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	chk_tbf_on_write: assert property (wr_buffer |=> st_r.tbf)
		else $error("transmit full not set by buffer write");

	chk_ovf_discard: assert property (done_e && st_r.rbf && !rd_buffer && !wide_chg
		|=> st_r.rov && $stable(st_r.rxbuf))
		else $error("overflow not flagged or word not dropped");

	chk_ovf_freeze: assert property (st_r.rov && !rd_buffer && !port_rst && !wr_status
		|=> $stable(st_r.bitcnt) && $stable(st_r.sck_out))
		else $error("port moved while overflow set");

	chk_read_clears: assert property (rd_buffer && !done_e |=> !st_r.rbf && !st_r.rov)
		else $error("buffer read did not clear full flag");

	chk_done_irq: assert property (done_e && st_r.irq_en && !wr_irq
		|=> st_r.irq_flag ##1 transfer_irq)
		else $error("completion did not raise interrupt");

	chk_word_length: assert property (done_e && master |-> st_r.halfcnt == {nbits, 1'b0} - (cke ? 6'h02 : 6'h01))
		else $error("word ended at wrong bit count");

	chk_frame_pulse: assert property ($fell(st_r.ss_out) && $past(port_on) && !$past(wide_chg)
		|-> st_r.state == ST_SHIFT && st_r.bitcnt == 5'h00)
		else $error("frame pulse ended outside start of word");

	chk_select_release: assert property ((sel_high && port_on)[*2] |-> !serial_data_out_pin_oe)
		else $error("data output driven while select high");

	chk_sleep_abort: assert property (sleep_mode |=> st_r.state == ST_IDLE && !shift_clock_pin_oe)
		else $error("transfer kept running in sleep");

	chk_out_disable: assert property (st_r.ctl[CT_OUT_DIS_BIT] |=> !serial_data_out_pin_oe)
		else $error("data output driven while disabled");

	chk_size_reset: assert property (wide_chg && !wr_buffer |=> st_r.state == ST_IDLE && !st_r.tbf)
		else $error("word size change did not reset port");

endmodule

// ### bench/spi_slave_model.sv
// far-side serial peripheral answering the port in master mode
`timescale 1ns/100ps
module spi_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic wide,
	input wire logic arm,
	input wire logic [15:0] tx_word,
	output logic miso,
	output logic [15:0] rx_word,
	output int nbits
);
	int idx;
	initial begin
		miso = 1'b0;
		rx_word = 16'h0000;
		nbits = 0;
		idx = 0;
	end
	// first bit presented before the first clock edge
	always @(posedge arm) begin
		idx = wide ? 15 : 7;
		nbits = 0;
		rx_word = 16'h0000;
		miso = tx_word[idx];
	end
	// sample on leading edge, msb arrives first
	always @(posedge sck) begin
		rx_word = {rx_word[14:0], mosi};
		nbits++;
	end
	// change on trailing edge; after the last bit the line shows garbage
	always @(negedge sck) begin
		if (idx > 0) begin
			idx--;
			miso = tx_word[idx];
		end else begin
			miso = ~miso;
		end
	end
endmodule

// ### bench/test_spi_port.sv
// self-checking bench for the serial port driven as master, then as slave with select
`timescale 1ns/100ps
module test_spi_port;
	import spi_port_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic [DATA_W-1:0] tx_word = '0;
	logic [DATA_W-1:0] reg_rdata, rx_word, d, w, v2;
	logic slave_on = 1'b0, sdi_bench = 1'b0, sck_in = 1'b0, ss_n = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
	logic arm = 1'b0, wide = 1'b0, dis = 1'b0;
	logic sdo, sdo_oe, sck, sck_oe, sdi, irq, oe_mid;
	int n_mismatch = 0, samples_checked = 0, seed = 5, nbits;

	always #20 core_clk = ~core_clk;

	spi_port spi_port_inst (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sleep_mode(sleep_mode), .idle_mode(idle_mode),
		.serial_data_in_pin(slave_on ? sdi_bench : sdi),
		.serial_data_out_pin(sdo), .serial_data_out_pin_oe(sdo_oe),
		.shift_clock_pin_in(sck_in), .shift_clock_pin_out(sck), .shift_clock_pin_oe(sck_oe),
		.slave_select_pin_n_in(ss_n), .slave_select_pin_n_out(), .slave_select_pin_n_oe(),
		.transfer_irq(irq));
	// released data line floats up to its pull-up level
	spi_slave_model spi_slave_model_inst (.sck(sck), .mosi(sdo_oe ? sdo : 1'b1), .wide(wide),
		.arm(arm), .tx_word(tx_word), .miso(sdi), .rx_word(rx_word), .nbits(nbits));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		v = reg_rdata;
	endtask
	task automatic rchk(input string n, input logic [ADDR_W-1:0] a, input logic [15:0] e);
		rd(a, d);
		chk(n, e, d);
	endtask
	function automatic logic [15:0] ctl(input logic wide_b, input logic dis_b);
		return 16'h013F | (16'(wide_b) << CT_WIDE_BIT) | (16'(dis_b) << CT_OUT_DIS_BIT);
	endfunction
	function automatic logic [15:0] fit(input logic [15:0] v, input logic wide_b);
		return wide_b ? v : {8'h00, v[7:0]};
	endfunction
	// one word out and in; waits on the done flag with a bounded poll
	task automatic xfer(input logic [15:0] v, input logic ien);
		int i;
		wr(OFS_IRQ, {14'h0000, ien, 1'b0});
		tx_word = 16'($random(seed));
		arm = 1'b1;
		#1 arm = 1'b0;
		wr(OFS_BUFFER, v);
		repeat (8) @(posedge core_clk);
		oe_mid = sdo_oe;
		d = '0;
		for (i = 0; i < 100 && d[IRQ_FLAG_BIT] !== 1'b1; i++)
			rd(OFS_IRQ, d);
		chk("done flag", 16'h0001, {15'h0000, d[IRQ_FLAG_BIT]});
		repeat (8) @(posedge core_clk);
	endtask
	// external master: sample output before each rise, present input with it
	task automatic slave_bits(input logic [15:0] v, input int nb, output logic [15:0] got);
		got = '0;
		for (int b = 15; b > 15 - nb; b--) begin
			@(negedge core_clk);
			got = {got[14:0], sdo};
			@(posedge core_clk);
			sdi_bench <= v[b];
			sck_in <= 1'b1;
			repeat (2) @(posedge core_clk);
			sck_in <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		$display("[ERR] run time expected done seen hang");
		end_sim();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		rchk("status reset", OFS_STATUS, 16'h0000);
		rchk("control reset", OFS_CONTROL, RST_CONTROL);
		rchk("buffer reset", OFS_BUFFER, RST_BUFFER);
		wr(12'h228, 16'($random(seed)));
		rchk("unmapped", 12'h228, 16'h0000);
		wr(OFS_CONTROL, ctl(1'b0, 1'b0));
		wr(OFS_STATUS, 16'h8000);
		rchk("status on", OFS_STATUS, 16'h8000);
		rchk("control", OFS_CONTROL, ctl(1'b0, 1'b0));
		for (int k = 0; k < 6; k++) begin
			dis = (k == 5);
			if (k == 3) begin
				wr(OFS_STATUS, 16'h0000);
				wide = 1'b1;
				wr(OFS_CONTROL, ctl(1'b1, 1'b0));
				wr(OFS_STATUS, 16'h8000);
			end
			if (dis)
				wr(OFS_CONTROL, ctl(1'b1, 1'b1));
			w = 16'($random(seed));
			if (k == 0)
				w = 16'hFFFF;
			if (k == 4)
				w = 16'h8001;
			xfer(w, k[0]);
			chk("irq", {15'h0000, k[0]}, {15'h0000, irq});
			chk("sent word", fit(dis ? 16'hFFFF : w, wide), rx_word);
			chk("bit count", wide ? 16'h0010 : 16'h0008, 16'(nbits));
			chk("data out enable", {15'h0000, ~dis}, {15'h0000, oe_mid});
			rchk("status full", OFS_STATUS, 16'h8001);
			rchk("buffer", OFS_BUFFER, fit(tx_word, wide));
			rchk("status read", OFS_STATUS, 16'h8000);
		end
		xfer(16'h1234, 1'b0);
		w = tx_word;
		xfer(16'h5678, 1'b0);
		rchk("overflow", OFS_STATUS, 16'h8041);
		arm = 1'b1;
		#1 arm = 1'b0;
		wr(OFS_BUFFER, 16'($random(seed)));
		repeat (80) @(posedge core_clk);
		chk("frozen", 16'h0000, 16'(nbits));
		rchk("kept word", OFS_BUFFER, w);
		repeat (200) @(posedge core_clk);
		rd(OFS_BUFFER, d);
		wr(OFS_STATUS, 16'hA000);
		idle_mode <= 1'b1;
		arm = 1'b1;
		#1 arm = 1'b0;
		wr(OFS_BUFFER, 16'h00A5);
		repeat (80) @(posedge core_clk);
		chk("idle halt", 16'h0000, 16'(nbits));
		idle_mode <= 1'b0;
		repeat (100) @(posedge core_clk);
		chk("idle resume", 16'h0010, 16'(nbits));
		wr(OFS_STATUS, 16'h8000);
		rd(OFS_BUFFER, d);
		wr(OFS_CONTROL, 16'h0580);
		slave_on <= 1'b1;
		wr(OFS_BUFFER, 16'h0F0F);
		ss_n <= 1'b0;
		slave_bits(16'h0000, 5, d);
		ss_n <= 1'b1;
		w = 16'($random(seed));
		wr(OFS_BUFFER, w);
		@(negedge core_clk);
		chk("select off oe", 16'h0000, {15'h0000, sdo_oe});
		@(posedge core_clk);
		ss_n <= 1'b0;
		v2 = 16'($random(seed));
		slave_bits(v2, 16, d);
		@(negedge core_clk);
		chk("select on oe", 16'h0001, {15'h0000, sdo_oe});
		@(posedge core_clk);
		ss_n <= 1'b1;
		chk("slave sent", w, d);
		rchk("slave received", OFS_BUFFER, v2);
		wr(OFS_STATUS, 16'h0000);
		wr(OFS_CONTROL, ctl(1'b1, 1'b1));
		wr(OFS_STATUS, 16'h8000);
		slave_on <= 1'b0;
		repeat (20) @(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk("sleep clock oe", 16'h0000, {15'h0000, sck_oe});
		sleep_mode <= 1'b0;
		repeat (4) @(posedge core_clk);
		rchk("control kept", OFS_CONTROL, ctl(1'b1, 1'b1));
		chk("master clock oe", 16'h0001, {15'h0000, sck_oe});
		wr(OFS_CONTROL, ctl(1'b1, 1'b1) | 16'h0040);
		repeat (8) @(posedge core_clk);
		chk("idle clock level", 16'h0001, {15'h0000, sck});
		end_sim();
	end
endmodule
